// ---- ccp_defs.svh ----
// constants of the contactless reader command parser
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_RXD 8'h08
`define A_TXD 8'h0C
`define A_CNT 8'h10
`define A_AMTL 8'h14
`define A_AMTH 8'h18
`define CH_ACK 8'h5E
`define CH_FAIL 8'h2A
`define CH_BAD 8'h21
`define CH_M 8'h4D
`define CH_0 8'h30
`define CH_1 8'h31
`define CH_2 8'h32
`define CH_3 8'h33
`define CH_4 8'h34
`define CH_5 8'h35
`define CH_A 8'h41
`define CH_B 8'h42
`define CH_U 8'h55
`define OP_T 8'h54
`define OP_WL 8'h77
`define OP_G 8'h47
`define OP_ON 8'h4F
`define OP_OFF 8'h6F
`define OP_REQ 8'h62
`define OP_AC 8'h63
`define OP_SEL 8'h66
`define OP_AU 8'h67
`define OP_RD 8'h68
`define OP_WR 8'h69
`define OP_VAL 8'h74
`define OP_DET 8'h57
`define OP_ACT 8'h58
`define OP_HLT 8'h78
`define OP_RS 8'h75
`define REQA 8'h26
`define WUPA 8'h52
`define REC_MIN 16'h0001
`define REC_MAX 16'h0186
`define BL_MAX 9'd272
`define BL_IMAX 16'h010F
`define PAN_MAX 8'd19
`define RX_N 5'd24
`define TX_N 10'd512
`define SEC_BIG 8'd32
`define SEC_LAST 8'd39
`define BLK4 8'd4
`define BLK16 8'd16
`endif

// ---- ccp_pkg.sv ----
// types shared by the reader command parser
package ccp_pkg;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_EXEC = 3'b001,
		ST_SCAN = 3'b010,
		ST_CARD = 3'b011
	} state_t;
	typedef enum logic [3:0]
	{
		CO_REQ  = 4'b0000,
		CO_ANTI = 4'b0001,
		CO_SEL  = 4'b0010,
		CO_AUTH = 4'b0011,
		CO_READ = 4'b0100,
		CO_WRT  = 4'b0101,
		CO_VAL  = 4'b0110,
		CO_ACT  = 4'b0111,
		CO_HALT = 4'b1000,
		CO_RSEC = 4'b1001
	} card_op_t;
	typedef struct packed
	{
		card_op_t    op;
		logic        type_b;
		logic        ul;
		logic        dflt;
		logic [7:0]  blk;
		logic [7:0]  arg;
		logic [7:0]  xblk;
	} card_cmd_t;
endpackage

// ---- reader_cmd_parser.sv ----
// host command interpreter with AHB-Lite register access
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
`include "ccp_defs.svh"
module reader_cmd_parser
(
	// clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rst_b_i,
	// AHB-Lite slave
	input  wire logic              hsel_i,
	input  wire logic [31:0]       haddr_i,
	input  wire logic [1:0]        htrans_i,
	input  wire logic              hwrite_i,
	input  wire logic [2:0]        hsize_i,
	input  wire logic [31:0]       hwdata_i,
	input  wire logic              hready_i,
	output logic [31:0]            hrdata_o,
	output logic                   hreadyout_o,
	output logic                   hresp_o,
	// card engine
	output ccp_pkg::card_cmd_t     card_cmd_o,
	output logic                   card_go_o,
	input  wire logic              card_done_i,
	input  wire logic              card_ok_i,
	input  wire logic              card_byte_vld_i,
	input  wire logic [7:0]        card_byte_i,
	input  wire logic [4:0]        card_fidx_i,
	output logic [7:0]             card_fbyte_o,
	// field state
	input  wire logic              card_here_i,
	input  wire logic              txn_done_i,
	output logic                   antenna_on_o
);
	import ccp_pkg::*;

	state_t st_r;
	logic [7:0] rx [0:23];
	logic [7:0] tx [0:511];
	logic [18:0][7:0] bl_pan [0:271];
	logic [7:0] bl_len [0:271];
	logic [4:0] rcnt_r;
	logic [9:0] tlen_r, rptr_r;
	logic ovf_r, auto_r, type_b_r, amt_v_r, wr_r, here_s1_r, here_r;
	logic [47:0] amt_r;
	logic [15:0] rec_cnt_r;
	logic [8:0] bl_cnt_r, scan_r;
	logic [7:0] wa_r;
	card_cmd_t e_cmd;
	logic [1:0] e_len;
	logic [7:0] e_b0, e_b1, e_b2;
	logic e_go, e_pfx, e_scan, e_fetch, e_rclr, e_amt, e_aclr, e_bclr, e_badd;
	logic e_ty, e_ant;
	logic [18:0][7:0] key;

	function automatic logic dig(input logic [7:0] x);
		dig = x >= `CH_0 && x <= 8'h39;
	endfunction
	function automatic logic hx(input logic [7:0] x);
		hx = dig(x) || (x >= `CH_A && x <= 8'h46);
	endfunction
	// digits run rx[f..f+c-1]
	function automatic logic drun(input int f, input logic [7:0] c);
		drun = 1'b1;
		for (int k = 0; k < 19; k++)
			if (k < int'(c) && !dig(rx[f + k]))
				drun = 1'b0;
	endfunction
	// block field: {ok, ul, value}
	function automatic logic [9:0] blkp(input int f, input logic u);
		logic [9:0] d;
		d = 10'(rx[f][3:0]) * 10'd100 + 10'(rx[f + 1][3:0]) * 10'd10 + 10'(rx[f + 2][3:0]);
		if (rx[f] == `CH_B || (u && rx[f] == `CH_U))
			blkp = {rx[f + 1] == 8'h00, rx[f] == `CH_U, rx[f + 2]};
		else
			blkp = {dig(rx[f]) && dig(rx[f + 1]) && dig(rx[f + 2]) && d < 10'd256, 1'b0, d[7:0]};
	endfunction

	// decode of the frame and bus
	wire busy = st_r != ST_IDLE;
	wire [7:0] op = rx[0];
	wire [7:0] sub = rx[1];
	wire [4:0] n = rcnt_r;
	wire [15:0] ridx = {rx[2], rx[3]};
	wire [8:0] bidx = {rx[2][0], rx[3]};
	wire [7:0] plen = rx[2];
	wire pan_ok = plen != 8'h00 && plen <= `PAN_MAX && 8'(n) == plen + 8'd3 && drun(3, plen);
	wire [9:0] b1p = blkp(1, 1'b0);
	wire [9:0] bwp = blkp(1, 1'b1);
	wire [9:0] bxp = blkp(9, 1'b0);
	wire [9:0] rem = tlen_r - rptr_r;
	wire aph = hsel_i && htrans_i[1] && hready_i;
	wire amap = haddr_i[31:5] == 27'h0;
	wire pop = aph && !hwrite_i && amap && haddr_i[7:0] == `A_TXD && !busy && rem != 10'h0;
	wire wctl = wr_r && wa_r == `A_CTRL;
	wire go = wctl && hwdata_i[1] && !busy;
	wire wrx = wr_r && wa_r == `A_RXD && !busy;
	wire hit = bl_len[scan_r] == plen && bl_pan[scan_r] == key;
	wire scan_end = hit || scan_r == bl_cnt_r - 9'd1;
	always_comb
	begin
		for (int k = 0; k < 19; k++)
			key[k] = k < int'(plen) ? rx[3 + k] : 8'h00;
	end
	wire [31:0] rd_val =
		!amap ? 32'h0 :
		haddr_i[7:0] == `A_CTRL ? {31'h0, auto_r} :
		haddr_i[7:0] == `A_STAT ? {6'h0, rem, 11'h0, ovf_r, amt_v_r, antenna_on_o, type_b_r, busy} :
		haddr_i[7:0] == `A_TXD ? {24'h0, pop ? tx[rptr_r[8:0]] : 8'h00} :
		haddr_i[7:0] == `A_CNT ? {7'h0, bl_cnt_r, rec_cnt_r} :
		haddr_i[7:0] == `A_AMTL ? amt_r[31:0] :
		haddr_i[7:0] == `A_AMTH ? {16'h0, amt_r[47:32]} : 32'h0;

	// command execution decode
	always_comb
	begin
		e_len = 2'd1;
		e_b0 = `CH_BAD;
		e_b1 = 8'h00;
		e_b2 = 8'h00;
		{e_go, e_pfx, e_scan, e_fetch, e_rclr, e_amt, e_aclr, e_bclr, e_badd} = 9'h0;
		{e_ty, e_ant} = 2'b00;
		e_cmd = '{op: CO_REQ, type_b: type_b_r, ul: 1'b0, dflt: 1'b0,
			blk: b1p[7:0], arg: 8'h00, xblk: bxp[7:0]};
		if (!ovf_r)
		case (op)
		`OP_T:
			if (sub == `CH_0 && n == 5'd2)
				{e_rclr, e_b0} = {1'b1, `CH_ACK};
			else if (sub == `CH_1 && n == 5'd8 && drun(2, 8'd6))
				{e_amt, e_b0} = amt_v_r ? {1'b0, `CH_FAIL} : {1'b1, `CH_ACK};
			else if (sub == `CH_2 && n == 5'd4 && ridx >= `REC_MIN && ridx <= `REC_MAX)
				{e_len, e_b0, e_b1, e_b2} = ridx > rec_cnt_r ?
					{2'd1, `CH_FAIL, 16'h0} : {2'd3, `CH_ACK, ridx};
			else if (sub == `CH_B && n == 5'd2)
				{e_len, e_b0, e_b1} = {2'd2, rec_cnt_r};
			else if (sub == `CH_5 && n == 5'd2)
				{e_aclr, e_b0} = {1'b1, `CH_ACK};
		`OP_WL:
			if (sub == `CH_0 && n == 5'd2)
				{e_bclr, e_b0} = {1'b1, `CH_ACK};
			else if (sub == `CH_1 && n == 5'd2)
				{e_len, e_b0, e_b1} = {2'd2, 7'h0, bl_cnt_r};
			else if (sub == `CH_2 && pan_ok)
				{e_badd, e_b0} = bl_cnt_r == `BL_MAX ? {1'b0, `CH_FAIL} : {1'b1, `CH_ACK};
			else if (sub == `CH_3 && pan_ok)
				{e_scan, e_b0} = {bl_cnt_r != 9'h0, `CH_0};
			else if (sub == `CH_4 && n == 5'd4 && ridx <= `BL_IMAX)
				{e_fetch, e_b0} = {bidx < bl_cnt_r, 8'h00};
		`OP_G:
			if (n == 5'd2 && (sub == `CH_0 || sub == `CH_4))
				{e_ty, e_b0} = {1'b1, `CH_ACK};
		`OP_ON, `OP_OFF:
			if (n == 5'd1)
				{e_ant, e_b0} = auto_r ? {1'b0, `CH_FAIL} : {1'b1, `CH_ACK};
		`OP_REQ:
			if (!type_b_r && n == 5'd1)
				{e_go, e_cmd.dflt, e_cmd.arg} = {2'b11, `WUPA};
			else if (!type_b_r && n == 5'd2 && (sub == `REQA || sub == `WUPA))
				{e_go, e_cmd.arg} = {1'b1, sub};
			else if (type_b_r && (n == 5'd1 || n == 5'd3))
				{e_go, e_cmd.dflt, e_cmd.arg} = {1'b1, n == 5'd1, sub};
		`OP_AC:
			if (n == (type_b_r ? 5'd2 : 5'd1))
				{e_go, e_cmd.op, e_cmd.arg} = {1'b1, CO_ANTI, sub};
		`OP_SEL:
			if (n == 5'd1)
				{e_go, e_pfx, e_cmd.op} = {2'b11, CO_SEL};
		`OP_AU:
			if (b1p[9] && n == 5'd6 && rx[4] >= `CH_0 && rx[4] <= `CH_4
				&& (rx[5] == `CH_A || rx[5] == `CH_B))
				{e_go, e_pfx, e_cmd.op, e_cmd.arg} = {2'b11, CO_AUTH, rx[4]};
			else if (b1p[9] && n == 5'd17 && (rx[4] == `CH_A || rx[4] == `CH_B)
				&& hx(rx[5]) && hx(rx[6]) && hx(rx[7]) && hx(rx[8]) && hx(rx[9])
				&& hx(rx[10]) && hx(rx[11]) && hx(rx[12]) && hx(rx[13])
				&& hx(rx[14]) && hx(rx[15]) && hx(rx[16]))
				{e_go, e_pfx, e_cmd.op, e_cmd.dflt, e_cmd.arg} = {2'b11, CO_AUTH, 1'b1, rx[4]};
		`OP_RD:
			if (b1p[9] && n == 5'd4)
				{e_go, e_cmd.op} = {1'b1, CO_READ};
		`OP_WR:
			if (bwp[9] && n == (bwp[8] ? 5'd8 : 5'd20))
				{e_go, e_pfx, e_cmd.op, e_cmd.ul, e_cmd.blk} = {2'b11, CO_WRT, bwp[8:0]};
		`OP_VAL:
			if (b1p[9] && rx[4] >= `CH_0 && rx[4] <= `CH_4
				&& (n == 5'd9 || (n == 5'd12 && rx[4] == `CH_3 && bxp[9])))
				{e_go, e_pfx, e_cmd.op, e_cmd.arg} = {2'b11, CO_VAL,
					rx[4] == `CH_3 && n == 5'd9 ? `CH_0 : rx[4]};
		`OP_DET:
			if (n == 5'd1)
				e_b0 = here_r ? `CH_M : `CH_FAIL;
		`OP_ACT:
			if (n == 5'd1)
				{e_go, e_cmd.op} = {1'b1, CO_ACT};
		`OP_HLT:
			if (n == 5'd1)
				{e_go, e_pfx, e_cmd.op} = {2'b11, CO_HALT};
		`OP_RS:
			if (b1p[9] && n == 5'd4)
				{e_go, e_cmd.op, e_cmd.arg} = {1'b1, CO_RSEC,
					b1p[7:0] >= `SEC_BIG && b1p[7:0] <= `SEC_LAST ? `BLK16 : `BLK4};
		default:
			e_b0 = `CH_BAD;
		endcase
		if (e_go)
			e_b0 = !antenna_on_o ? `CH_FAIL : `CH_ACK;
		if (e_go && !antenna_on_o)
			e_go = 1'b0;
	end

	// control state and bus slave
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st_r <= ST_IDLE;
			{rcnt_r, tlen_r, rptr_r, rec_cnt_r, bl_cnt_r, scan_r, wa_r} <= '0;
			{ovf_r, auto_r, type_b_r, amt_v_r, wr_r, here_s1_r, here_r} <= '0;
			{amt_r, hrdata_o, hresp_o, card_go_o, antenna_on_o, card_fbyte_o} <= '0;
			hreadyout_o <= 1'b1;
			card_cmd_o <= '0;
		end
		else
		begin
			{here_r, here_s1_r} <= {here_s1_r, card_here_i};
			wr_r <= aph && hwrite_i && amap;
			wa_r <= haddr_i[7:0];
			hrdata_o <= aph && !hwrite_i ? rd_val : 32'h0;
			card_fbyte_o <= card_fidx_i < `RX_N ? rx[card_fidx_i] : 8'h00;
			card_go_o <= st_r == ST_EXEC && e_go;
			if (pop)
				rptr_r <= rptr_r + 10'd1;
			if (wctl)
				auto_r <= hwdata_i[0];
			if (wctl && hwdata_i[2] && !busy)
				{rcnt_r, ovf_r} <= '0;
			else if (wrx)
				{rcnt_r, ovf_r} <= rcnt_r == `RX_N ? {rcnt_r, 1'b1} : {rcnt_r + 5'd1, 1'b0};
			if (txn_done_i && rec_cnt_r != `REC_MAX)
				rec_cnt_r <= rec_cnt_r + 16'd1;
			case (st_r)
			ST_IDLE:
				if (go)
					{st_r, rptr_r} <= {ST_EXEC, 10'h0};
			ST_EXEC:
			begin
				tlen_r <= e_fetch ? {2'b00, bl_len[bidx]} :
					(e_go && !e_pfx) ? 10'h000 : {8'h0, e_len};
				rcnt_r <= 5'd0;
				ovf_r <= 1'b0;
				scan_r <= 9'h0;
				card_cmd_o <= e_cmd;
				if (e_rclr)
					rec_cnt_r <= {15'h0, txn_done_i}; // a record stored now survives
				if (e_amt)
					{amt_r, amt_v_r} <= {rx[2], rx[3], rx[4], rx[5], rx[6], rx[7], 1'b1};
				if (e_aclr)
					{amt_r, amt_v_r} <= '0;
				if (e_bclr)
					bl_cnt_r <= 9'h0;
				if (e_badd)
					bl_cnt_r <= bl_cnt_r + 9'd1;
				if (e_ty)
					type_b_r <= sub == `CH_4;
				if (e_ant)
					antenna_on_o <= op == `OP_ON;
				st_r <= e_scan ? ST_SCAN : e_go ? ST_CARD : ST_IDLE;
			end
			ST_SCAN:
			begin
				scan_r <= scan_r + 9'd1;
				if (scan_end)
					st_r <= ST_IDLE;
			end
			ST_CARD:
				if (card_done_i)
				begin
					st_r <= ST_IDLE;
					if (!card_ok_i)
						tlen_r <= 10'd1;
				end
				else if (card_byte_vld_i && tlen_r < `TX_N)
					tlen_r <= tlen_r + 10'd1;
			default:
				st_r <= ST_IDLE;
			endcase
		end
	end

	// frame, answer and exception file storage
	always_ff @(posedge sys_clk_i)
	begin
		if (wrx && rcnt_r < `RX_N)
			rx[rcnt_r] <= hwdata_i[7:0];
		if (st_r == ST_EXEC && e_badd)
			{bl_pan[bl_cnt_r], bl_len[bl_cnt_r]} <= {key, plen};
		if (st_r == ST_EXEC)
		begin
			{tx[0], tx[1], tx[2]} <= {e_b0, e_b1, e_b2};
			if (e_fetch)
				for (int k = 0; k < 19; k++)
					tx[k] <= bl_pan[bidx][k];
		end
		else if (st_r == ST_SCAN && scan_end)
			tx[0] <= hit ? `CH_1 : `CH_0;
		else if (st_r == ST_CARD && card_done_i && !card_ok_i)
			tx[0] <= `CH_FAIL;
		else if (st_r == ST_CARD && card_byte_vld_i && tlen_r < `TX_N)
			tx[tlen_r[8:0]] <= card_byte_i;
	end

	// checks
	wire ex = st_r == ST_EXEC;
	property p_ant;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		ex && !ovf_r && n == 5'd1 && auto_r && (op == `OP_ON || op == `OP_OFF)
		|=> tx[0] == `CH_FAIL && $stable(antenna_on_o);
	endproperty
	a_ant: assert property (p_ant) else $error("antenna changed in auto read");
	property p_tyb;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		ex && !ovf_r && op == `OP_G && sub == `CH_4 && n == 5'd2 |=> type_b_r ##1 type_b_r;
	endproperty
	a_tyb: assert property (p_tyb) else $error("type B not chosen");
	property p_wupa;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		ex && !ovf_r && op == `OP_REQ && !type_b_r && n == 5'd1 && antenna_on_o
		|=> card_go_o && card_cmd_o.arg == `WUPA ##1 !card_go_o;
	endproperty
	a_wupa: assert property (p_wupa) else $error("default request not wake-up");
	property p_bad;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		ex && ovf_r |=> tx[0] == `CH_BAD && tlen_r == 10'd1 && st_r == ST_IDLE;
	endproperty
	a_bad: assert property (p_bad) else $error("bad frame not refused");
	property p_fail;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		st_r == ST_CARD && card_done_i && !card_ok_i |=> tx[0] == `CH_FAIL && tlen_r == 10'd1;
	endproperty
	a_fail: assert property (p_fail) else $error("card failure not reported");
	property p_hold;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		busy && !ex && wr_r && wa_r == `A_RXD |=> $stable(rcnt_r);
	endproperty
	a_hold: assert property (p_hold) else $error("frame grew while busy");
	property p_cnt;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		ex && !ovf_r && op == `OP_T && sub == `CH_B && n == 5'd2
		|=> tlen_r == 10'd2 && tx[1] == $past(rec_cnt_r[7:0]);
	endproperty
	a_cnt: assert property (p_cnt) else $error("record count answer wrong");
	property p_det;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		ex && !ovf_r && op == `OP_DET && n == 5'd1 && here_r |=> tx[0] == `CH_M;
	endproperty
	a_det: assert property (p_det) else $error("detection missed");
	property p_full;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		bl_cnt_r <= `BL_MAX;
	endproperty
	a_full: assert property (p_full) else $error("exception file overfilled");
	property p_pfx;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		ex && e_go |=> tlen_r == {9'h000, $past(e_pfx)} && (!$past(e_pfx) || tx[0] == `CH_ACK);
	endproperty
	a_pfx: assert property (p_pfx) else $error("acknowledge prefix wrong");
	property p_miss;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		ex && !ovf_r && op == `OP_WL && sub == `CH_4 && n == 5'd4 && ridx <= `BL_IMAX
		&& bidx >= bl_cnt_r |=> tx[0] == 8'h00 && tlen_r == 10'd1;
	endproperty
	a_miss: assert property (p_miss) else $error("missing entry not answered 00h");
	c_card: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		card_go_o ##[1:50] card_done_i && card_ok_i);
	c_scan: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		st_r == ST_SCAN && hit);
	c_pop: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) pop ##1 pop);
	c_ovf: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) ex && ovf_r);
endmodule

// ---- card_engine_model.sv ----
// behavioural card engine facing the parser's card port
`timescale 1ns/100ps
module card_engine_model
(
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_b_i,
	// bench controls
	input  wire logic [8:0] n_bytes_i,
	input  wire logic       ok_i,
	input  wire logic [3:0] delay_i,
	// parser side
	input  wire logic       go_i,
	output logic            done_o,
	output logic            ok_o,
	output logic            vld_o,
	output logic [7:0]      byte_o,
	output logic [4:0]      fidx_o
);
	logic       busy_r;
	logic       pass_r;
	logic [3:0] wait_r;
	logic [8:0] left_r;
	logic [7:0] idx_r;
	// wait, stream answer bytes one a cycle, then close with done
	always @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			{busy_r, pass_r, done_o, ok_o, vld_o} <= 5'h00;
			{wait_r, left_r, idx_r, byte_o, fidx_o} <= 34'h0;
		end
		else
		begin
			done_o <= 1'b0;
			vld_o <= 1'b0;
			ok_o <= ~ok_o; // meaningless outside done
			byte_o <= ~byte_o; // idle data keeps moving
			fidx_o <= fidx_o + 5'h01; // frame index sweeps
			if (go_i)
			begin
				busy_r <= 1'b1;
				pass_r <= ok_i;
				wait_r <= delay_i;
				left_r <= ok_i ? n_bytes_i : 9'h000;
				idx_r <= 8'h00;
			end
			else if (busy_r && wait_r != 4'h0)
				wait_r <= wait_r - 4'h1;
			else if (busy_r && left_r != 9'h000)
			begin
				vld_o <= 1'b1;
				byte_o <= 8'hC0 + idx_r;
				idx_r <= idx_r + 8'h01;
				left_r <= left_r - 9'h001;
			end
			else if (busy_r)
			begin
				done_o <= 1'b1;
				ok_o <= pass_r;
				busy_r <= 1'b0;
			end
		end
	end
endmodule

// ---- contactless_reader_command_parser_tb.sv ----
// self-checking bench of the reader command parser
`timescale 1ns/100ps
`include "ccp_defs.svh"
`define CHK(n,e,s) begin check_count++; if ((e) !== (s)) begin num_errors++; \
	$display("[ERR] %s exp %h got %h", n, e, s); end end
module contactless_reader_command_parser_tb;
	import ccp_pkg::*;
	typedef logic [7:0] bq_t[$];
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'b00;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	card_cmd_t   cmd;
	logic        go, done, ok, vld, ant;
	logic        here = 1'b0;
	logic        txn = 1'b0;
	logic [7:0]  cbyte;
	logic [4:0]  fidx;
	logic [7:0]  fbyte;
	logic [8:0]  eng_n = 9'h000;
	logic        eng_ok = 1'b1;
	logic [3:0]  eng_dly = 4'h0;
	logic        auto = 1'b0;
	logic [31:0] rd;
	logic [31:0] seed = 32'd12;
	logic [7:0]  b;
	bq_t         f;
	int          num_errors = 0;
	int          check_count = 0;
	int          cyc = 0;
	int          n;
	// clock, design and card engine
	always #2.5 sys_clk = ~sys_clk;
	reader_cmd_parser dut_u (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
		.hresp_o(hresp), .card_cmd_o(cmd), .card_go_o(go), .card_done_i(done),
		.card_ok_i(ok), .card_byte_vld_i(vld), .card_byte_i(cbyte), .card_fidx_i(fidx),
		.card_fbyte_o(fbyte), .card_here_i(here), .txn_done_i(txn), .antenna_on_o(ant));
	card_engine_model eng_u (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .n_bytes_i(eng_n),
		.ok_i(eng_ok), .delay_i(eng_dly), .go_i(go), .done_o(done), .ok_o(ok),
		.vld_o(vld), .byte_o(cbyte), .fidx_o(fidx));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected engine answer, optionally behind an acknowledge
	function automatic bq_t eng(input int n, input logic ack);
		bq_t q;
		q = {};
		if (ack)
			q.push_back(`CH_ACK);
		for (int i = 0; i < n; i++)
			q.push_back(8'hC0 + i[7:0]);
		return q;
	endfunction
	function automatic bq_t dec3(input logic [7:0] v);
		return '{8'h30 + v / 100, 8'h30 + (v / 10) % 10, 8'h30 + v % 10};
	endfunction
	task wrap_up();
		if (num_errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// one single word transfer, read data left in rd
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge sys_clk); while (hready !== 1'b1);
		rd = hrdata;
		`CHK("resp", 1'b0, hresp)
	endtask
	// send a frame, run it, wait until idle, compare the whole answer
	task run(input bq_t fr, input bq_t e);
		ahb(1'b1, `A_CTRL, {29'h0, 3'b100} | auto);
		foreach (fr[i])
			ahb(1'b1, `A_RXD, {24'h0, fr[i]});
		ahb(1'b1, `A_CTRL, {29'h0, 3'b010} | auto);
		@(posedge sys_clk);
		do ahb(1'b0, `A_STAT, 32'h0); while (rd[0] !== 1'b0);
		`CHK("answer length", e.size(), rd[25:16])
		foreach (e[i])
		begin
			ahb(1'b0, `A_TXD, 32'h0);
			`CHK("answer byte", e[i], rd[7:0])
		end
		// frame port shows the opcode one cycle after index 0
		do @(posedge sys_clk); while (fidx !== 5'd0);
		@(posedge sys_clk);
		`CHK("frame byte", fr[0], fbyte)
	endtask
	// hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			num_errors++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		ahb(1'b0, `A_STAT, 32'h0);
		`CHK("stat", 32'h0, rd)
		run('{8'h99}, '{`CH_BAD});
		n = 1 + rnd() % 5;
		repeat (n)
		begin
			txn <= 1'b1;
			@(posedge sys_clk);
			txn <= 1'b0;
			@(posedge sys_clk);
		end
		run('{`OP_T, `CH_B}, '{8'h00, n[7:0]});
		run('{`OP_T, `CH_2, 8'h00, n[7:0]}, '{`CH_ACK, 8'h00, n[7:0]});
		run('{`OP_T, `CH_2, 8'h00, 8'h00}, '{`CH_BAD});
		run('{`OP_T, `CH_2, 8'h01, 8'h87}, '{`CH_BAD});
		run('{`OP_T, `CH_0}, '{`CH_ACK});
		run('{`OP_T, `CH_B}, '{8'h00, 8'h00});
		f = '{`OP_T, `CH_1, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36};
		run(f, '{`CH_ACK});
		ahb(1'b0, `A_AMTH, 32'h0);
		`CHK("amount", 32'h3132, rd)
		ahb(1'b0, `A_AMTL, 32'h0);
		`CHK("amount low", 32'h33343536, rd)
		run(f, '{`CH_FAIL});
		run('{`OP_T, `CH_5}, '{`CH_ACK});
		run(f, '{`CH_ACK});
		run('{`OP_WL, `CH_0}, '{`CH_ACK});
		run('{`OP_WL, `CH_2, 8'h03, 8'h31, 8'h32, 8'h33}, '{`CH_ACK});
		run('{`OP_WL, `CH_1}, '{8'h00, 8'h01});
		run('{`OP_WL, `CH_3, 8'h03, 8'h31, 8'h32, 8'h33}, '{`CH_1});
		run('{`OP_WL, `CH_3, 8'h03, 8'h31, 8'h32, 8'h34}, '{`CH_0});
		run('{`OP_WL, `CH_4, 8'h00, 8'h05}, '{8'h00});
		run('{`OP_WL, `CH_4, 8'h00, 8'h00}, '{8'h31, 8'h32, 8'h33});
		run('{`OP_WL, `CH_4, 8'h01, 8'h10}, '{`CH_BAD});
		run('{`OP_WL, 8'h39}, '{`CH_BAD});
		f = {};
		repeat (25)
			f.push_back(`OP_DET);
		run(f, '{`CH_BAD});
		ahb(1'b0, `A_CNT, 32'h0);
		`CHK("file count", 9'd1, rd[24:16])
		run('{`OP_REQ}, '{`CH_FAIL});
		auto = 1'b1;
		run('{`OP_ON}, '{`CH_FAIL});
		`CHK("antenna", 1'b0, ant)
		auto = 1'b0;
		run('{`OP_ON}, '{`CH_ACK});
		`CHK("antenna", 1'b1, ant)
		eng_n <= 9'd2;
		run('{`OP_REQ}, eng(2, 1'b0));
		`CHK("dflt", 1'b1, cmd.dflt)
		`CHK("arg", `WUPA, cmd.arg)
		run('{`OP_REQ, `REQA}, eng(2, 1'b0));
		`CHK("arg", `REQA, cmd.arg)
		`CHK("dflt", 1'b0, cmd.dflt)
		run('{`OP_G, `CH_4}, '{`CH_ACK});
		eng_n <= 9'd16;
		run('{`OP_REQ}, eng(16, 1'b0));
		`CHK("type b", 1'b1, cmd.type_b)
		`CHK("dflt", 1'b1, cmd.dflt)
		run('{`OP_REQ, 8'h00, 8'h00}, eng(16, 1'b0));
		`CHK("dflt", 1'b0, cmd.dflt)
		eng_n <= 9'd12;
		run('{`OP_AC, 8'h05}, eng(12, 1'b0));
		`CHK("op", CO_ANTI, cmd.op)
		run('{`OP_G, `CH_0}, '{`CH_ACK});
		run('{`OP_AC}, eng(12, 1'b0));
		run('{`OP_G, 8'h37}, '{`CH_BAD});
		eng_n <= 9'd1;
		run('{`OP_SEL}, eng(1, 1'b1));
		eng_n <= 9'd16;
		repeat (4)
		begin
			b = 8'(rnd());
			eng_dly <= 4'(rnd());
			run({`OP_RD, dec3(b)}, eng(16, 1'b0));
			`CHK("block", b, cmd.blk)
			run('{`OP_RD, `CH_B, 8'h00, b}, eng(16, 1'b0));
			`CHK("block", b, cmd.blk)
		end
		eng_ok <= 1'b0;
		run('{`OP_RD, 8'h30, 8'h30, 8'h31}, '{`CH_FAIL});
		eng_ok <= 1'b1;
		run('{`OP_RD, 8'h32, 8'h35, 8'h36}, '{`CH_BAD});
		eng_n <= 9'd0;
		run('{`OP_WR, `CH_U, 8'h00, 8'h05, 8'h11, 8'h22, 8'h33, 8'h44}, '{`CH_ACK});
		`CHK("ul", 1'b1, cmd.ul)
		`CHK("block", 8'h05, cmd.blk)
		f = {`OP_WR, dec3(8'd5)};
		repeat (16)
			f.push_back(8'(rnd()));
		run(f, '{`CH_ACK});
		`CHK("ul", 1'b0, cmd.ul)
		for (int k = 0; k < 5; k++)
		begin
			f = '{`OP_VAL, 8'h30, 8'h31, 8'h30, 8'h30 + k[7:0], 8'h00, 8'h00, 8'h00, 8'h01};
			run(f, '{`CH_ACK});
			`CHK("mode", (k == 3) ? `CH_0 : 8'h30 + k[7:0], cmd.arg)
		end
		f = {`OP_VAL, dec3(8'd10), `CH_3, 8'h00, 8'h00, 8'h00, 8'h01, dec3(8'd9)};
		run(f, '{`CH_ACK});
		`CHK("mode", `CH_3, cmd.arg)
		`CHK("transfer", 8'd9, cmd.xblk)
		eng_n <= 9'd4;
		run({`OP_RS, dec3(8'd33)}, eng(4, 1'b0));
		`CHK("blocks", `BLK16, cmd.arg)
		run({`OP_RS, dec3(8'd31)}, eng(4, 1'b0));
		`CHK("blocks", `BLK4, cmd.arg)
		eng_n <= 9'd0;
		run({`OP_AU, dec3(8'd7), `CH_2, `CH_A}, '{`CH_ACK});
		`CHK("key index", `CH_2, cmd.arg)
		f = {`OP_AU, dec3(8'd7), `CH_B};
		repeat (12)
			f.push_back(8'h46);
		run(f, '{`CH_ACK});
		`CHK("key type", `CH_B, cmd.arg)
		run({`OP_AU, dec3(8'd7), `CH_2, 8'h43}, '{`CH_BAD});
		here <= 1'b1;
		repeat (3) @(posedge sys_clk);
		run('{`OP_DET}, '{`CH_M});
		here <= 1'b0;
		repeat (3) @(posedge sys_clk);
		run('{`OP_DET}, '{`CH_FAIL});
		eng_n <= 9'd7;
		run('{`OP_ACT}, eng(7, 1'b0));
		`CHK("op", CO_ACT, cmd.op)
		eng_n <= 9'd0;
		run('{`OP_HLT}, '{`CH_ACK});
		`CHK("op", CO_HALT, cmd.op)
		run('{`OP_OFF}, '{`CH_ACK});
		`CHK("antenna", 1'b0, ant)
		run('{`OP_SEL}, '{`CH_FAIL});
		ahb(1'b0, 8'h1C, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		wrap_up();
	end
endmodule
